// [verilog/odt_pkg.sv]
// constants, register map and types shared by the on-demand/rx-timeout block
// Function
// - start index of on-demand data comes from a settings register
// - each port keeps its own start, count and timeout settings
// - invalid start index or word count sets that port's error flag
// - a receive pause longer than the timeout, in 10 ms steps, is an error
// - full range accepts 1 to 3276 steps; zero acts as 100 ms
// - reduced range accepts 1 to 255 steps; zero acts as 100 ms
// - format, station and timeout writes act only after power-up
// - stored parameters win over program-written settings
`default_nettype none
package odt_pkg;
  localparam int NPORT = 2;
  localparam int PORT_BIT = 5;
  // per-port offsets, port select in address bit PORT_BIT
  localparam logic [4:0] OFF_START = 5'h00;
  localparam logic [4:0] OFF_COUNT = 5'h04;
  localparam logic [4:0] OFF_TMO = 5'h08;
  localparam logic [4:0] OFF_FMT = 5'h0c;
  localparam logic [4:0] OFF_STN = 5'h10;
  localparam logic [4:0] OFF_ACT_TMO = 5'h14;
  localparam logic [4:0] OFF_ACT_FMT = 5'h18;
  localparam logic [4:0] OFF_ACT_STN = 5'h1c;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_FLAGS = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  localparam logic [7:0] OFF_MASK = 8'h4c;
  // status and flag field positions (one bit per port each)
  localparam int ST_ODERR = 0;
  localparam int ST_RXTO = 2;
  localparam int ST_DONE = 4;
  localparam int ST_W = 6;
  localparam int FL_SENDING = 0;
  localparam int FL_ODERR = 2;
  localparam logic [15:0] RST_SETTING = 16'h0000;
  localparam logic [ST_W-1:0] RST_STATUS = 6'h00;
  localparam logic [15:0] OD_MAX_COUNT = 16'h0040;
  localparam logic [15:0] TMO_MAX_FULL = 16'h0ccc;
  localparam logic [15:0] TMO_MAX_RED = 16'h00ff;
  localparam int TICK_MS = 10;
  localparam int TMO_ZERO_MS = 100;
  localparam logic [15:0] TMO_ZERO_STEPS = 16'(TMO_ZERO_MS / TICK_MS);
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic {
    OD_IDLE = 1'b0,
    OD_BUSY = 1'b1
  } odt_od_state_t;
endpackage
`default_nettype wire

// [verilog/odt_rx_if.sv]
// carrier between the control logic and one receive-interruption timer
`default_nettype none
interface odt_rx_if;
  logic tick;
  logic charIn;
  logic msgEnd;
  logic [15:0] limit;
  logic expired;
  modport ctrl(output tick, output charIn, output msgEnd, output limit,
               input expired);
  modport timer(input tick, input charIn, input msgEnd, input limit,
                output expired);
endinterface
`default_nettype wire

// [verilog/odt_tick_div.sv]
// divider giving a one-cycle enable every timeout step
`default_nettype none
module odt_tick_div #(
  parameter int CYCLES = odt_pkg::TICK_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end
endmodule
`default_nettype wire

// [verilog/odt_rx_timer.sv]
// receive-interruption timer for one port
`default_nettype none
module odt_rx_timer (
  input wire logic core_clk,
  input wire logic rst,
  odt_rx_if.timer bus
);
  logic running;
  logic [15:0] steps;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      running <= 1'b0;
      steps <= '0;
      bus.expired <= 1'b0;
    end else begin
      bus.expired <= 1'b0;
      if (bus.msgEnd) begin
        running <= 1'b0;
      end else if (bus.charIn) begin
        running <= 1'b1;
        steps <= '0;
      end else if (running && bus.tick) begin
        if (steps + 16'h0001 >= bus.limit) begin
          bus.expired <= 1'b1;
          running <= 1'b0;
        end else begin
          steps <= steps + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/odt_top.sv]
// on-demand send setup and receive timeout control with apb registers
`default_nettype none
module odt_top #(
  parameter int TICK_CYCLES = odt_pkg::TICK_CYCLES_DEF,
  parameter bit FULL_RANGE = 1'b1,
  parameter logic [16:0] DATA_WORDS = 17'h01f40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic powerGood,
  input wire logic [1:0] paramValid,
  input wire logic [31:0] paramTimeout,
  input wire logic [31:0] paramFormat,
  input wire logic [31:0] paramStation,
  input wire logic [1:0] rxChar,
  input wire logic [1:0] rxMsgEnd,
  input wire logic [1:0] txDone,
  output logic [1:0] odGo,
  output logic [31:0] odStartOut,
  output logic [31:0] odCountOut,
  output logic [1:0] rxError,
  output logic [31:0] linkFormat,
  output logic [31:0] linkStation,
  output logic [31:0] linkTimeout
);
  localparam int NP = odt_pkg::NPORT;
  localparam int SYW = 2 + 32 * 3 + 1;
  localparam logic [15:0] TMO_MAX =
    FULL_RANGE ? odt_pkg::TMO_MAX_FULL : odt_pkg::TMO_MAX_RED;

  // pins from outside the clock domain pass two flip-flops
  logic [SYW-1:0] syncA;
  logic [SYW-1:0] syncB;
  logic pgPrev;
  logic [1:0] pvS;
  logic [31:0] ptS;
  logic [31:0] pfS;
  logic [31:0] psS;
  logic pgS;
  logic powerUp;

  always_ff @(posedge core_clk) begin
    syncA <= {paramValid, paramTimeout, paramFormat, paramStation, powerGood};
    syncB <= syncA;
  end

  assign {pvS, ptS, pfS, psS, pgS} = syncB;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pgPrev <= 1'b0;
    end else begin
      pgPrev <= pgS;
    end
  end

  assign powerUp = pgS & ~pgPrev;

  // apb slave: one wait state, commit at the edge that sees pready
  logic access;
  logic commit;
  logic wrEn;
  logic [31:0] next_prdata;
  logic next_hit;
  logic [4:0] lo;
  logic inPort;
  logic pIdx;

  assign access = psel & penable;
  assign commit = access & pready;
  assign wrEn = commit & pwrite;
  assign lo = paddr[4:0];
  assign inPort = (paddr[7:6] == 2'b00);
  assign pIdx = paddr[odt_pkg::PORT_BIT];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access & ~pready;
      if (access && !pready) begin
        pslverr <= ~next_hit;
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // per-port copies of every setting
  logic [15:0] odStart [NP];
  logic [15:0] odCount [NP];
  logic [15:0] pendTmo [NP];
  logic [15:0] pendFmt [NP];
  logic [15:0] pendStn [NP];
  logic [15:0] actTmo [NP];
  logic [15:0] actFmt [NP];
  logic [15:0] actStn [NP];
  logic [NP-1:0] sending;
  logic [NP-1:0] odErr;
  logic [NP-1:0] evErr;
  logic [NP-1:0] evTo;
  logic [NP-1:0] evDone;
  logic [NP-1:0] goReq;
  logic tick;

  assign goReq = wrEn && paddr == odt_pkg::OFF_CTRL ? pwdata[NP-1:0] : '0;

  odt_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic portWr;
      logic invalid;
      logic [16:0] endIdx;
      logic [15:0] limit;
      odt_pkg::odt_od_state_t state;
      odt_rx_if rxBus ();

      assign portWr = wrEn && inPort && pIdx == 1'(p);
      assign endIdx = {1'b0, odStart[p]} + {1'b0, odCount[p]};
      assign invalid = odCount[p] == 16'h0000 ||
        odCount[p] > odt_pkg::OD_MAX_COUNT || endIdx > DATA_WORDS;

      // start and count are frozen while this port sends
      always_ff @(posedge core_clk) begin
        if (rst) begin
          odStart[p] <= odt_pkg::RST_SETTING;
          odCount[p] <= odt_pkg::RST_SETTING;
        end else if (portWr && state == odt_pkg::OD_IDLE) begin
          if (lo == odt_pkg::OFF_START) begin
            odStart[p] <= pwdata[15:0];
          end
          if (lo == odt_pkg::OFF_COUNT) begin
            odCount[p] <= pwdata[15:0];
          end
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          pendTmo[p] <= odt_pkg::RST_SETTING;
          pendFmt[p] <= odt_pkg::RST_SETTING;
          pendStn[p] <= odt_pkg::RST_SETTING;
        end else if (portWr) begin
          if (lo == odt_pkg::OFF_TMO) begin
            pendTmo[p] <= pwdata[15:0];
          end
          if (lo == odt_pkg::OFF_FMT) begin
            pendFmt[p] <= pwdata[15:0];
          end
          if (lo == odt_pkg::OFF_STN) begin
            pendStn[p] <= pwdata[15:0];
          end
        end
      end

      // written settings reach the link only at power-up
      always_ff @(posedge core_clk) begin
        if (rst) begin
          actTmo[p] <= odt_pkg::RST_SETTING;
          actFmt[p] <= odt_pkg::RST_SETTING;
          actStn[p] <= odt_pkg::RST_SETTING;
        end else if (powerUp) begin
          if (pvS[p]) begin
            actTmo[p] <= ptS[16*p +: 16];
            actFmt[p] <= pfS[16*p +: 16];
            actStn[p] <= psS[16*p +: 16];
          end else begin
            actTmo[p] <= pendTmo[p];
            actFmt[p] <= pendFmt[p];
            actStn[p] <= pendStn[p];
          end
        end
      end

      // zero means 100 ms; values above the range clamp to its top
      always_ff @(posedge core_clk) begin
        if (rst) begin
          limit <= odt_pkg::TMO_ZERO_STEPS;
        end else if (actTmo[p] == 16'h0000) begin
          limit <= odt_pkg::TMO_ZERO_STEPS;
        end else if (actTmo[p] > TMO_MAX) begin
          limit <= TMO_MAX;
        end else begin
          limit <= actTmo[p];
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          odErr[p] <= 1'b0;
        end else begin
          odErr[p] <= invalid;
        end
      end

      assign evErr[p] = (invalid & ~odErr[p]) | (goReq[p] & invalid);

      always_ff @(posedge core_clk) begin
        if (rst) begin
          state <= odt_pkg::OD_IDLE;
          odGo[p] <= 1'b0;
          odStartOut[16*p +: 16] <= '0;
          odCountOut[16*p +: 16] <= '0;
          evDone[p] <= 1'b0;
        end else begin
          odGo[p] <= 1'b0;
          evDone[p] <= 1'b0;
          case (state)
            odt_pkg::OD_IDLE: begin
              if (goReq[p] && !invalid) begin
                state <= odt_pkg::OD_BUSY;
                odGo[p] <= 1'b1;
                odStartOut[16*p +: 16] <= odStart[p];
                odCountOut[16*p +: 16] <= odCount[p];
              end
            end
            odt_pkg::OD_BUSY: begin
              if (txDone[p]) begin
                state <= odt_pkg::OD_IDLE;
                evDone[p] <= 1'b1;
              end
            end
            default: state <= odt_pkg::OD_IDLE;
          endcase
        end
      end

      assign sending[p] = (state == odt_pkg::OD_BUSY);
      assign rxBus.tick = tick;
      assign rxBus.charIn = rxChar[p];
      assign rxBus.msgEnd = rxMsgEnd[p];
      assign rxBus.limit = limit;
      assign evTo[p] = rxBus.expired;

      odt_rx_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .bus(rxBus)
      );

      always_ff @(posedge core_clk) begin
        if (rst) begin
          rxError[p] <= 1'b0;
        end else begin
          rxError[p] <= rxBus.expired;
        end
      end

      assign linkFormat[16*p +: 16] = actFmt[p];
      assign linkStation[16*p +: 16] = actStn[p];
      assign linkTimeout[16*p +: 16] = limit;
    end
  endgenerate

  // sticky status, write one to clear, a new event beats the clear
  logic [odt_pkg::ST_W-1:0] status;
  logic [odt_pkg::ST_W-1:0] mask;
  logic [odt_pkg::ST_W-1:0] events;
  logic [odt_pkg::ST_W-1:0] clr;

  assign events = {evDone, evTo, evErr};
  assign clr = wrEn && paddr == odt_pkg::OFF_STATUS ?
    pwdata[odt_pkg::ST_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= odt_pkg::RST_STATUS;
    end else begin
      status <= (status & ~clr) | events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask <= odt_pkg::RST_STATUS;
    end else if (wrEn && paddr == odt_pkg::OFF_MASK) begin
      mask <= pwdata[odt_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_comb begin
    next_prdata = '0;
    next_hit = 1'b1;
    if (inPort) begin
      case (lo)
        odt_pkg::OFF_START: next_prdata[15:0] = odStart[pIdx];
        odt_pkg::OFF_COUNT: next_prdata[15:0] = odCount[pIdx];
        odt_pkg::OFF_TMO: next_prdata[15:0] = pendTmo[pIdx];
        odt_pkg::OFF_FMT: next_prdata[15:0] = pendFmt[pIdx];
        odt_pkg::OFF_STN: next_prdata[15:0] = pendStn[pIdx];
        odt_pkg::OFF_ACT_TMO: next_prdata[15:0] = actTmo[pIdx];
        odt_pkg::OFF_ACT_FMT: next_prdata[15:0] = actFmt[pIdx];
        odt_pkg::OFF_ACT_STN: next_prdata[15:0] = actStn[pIdx];
        default: next_hit = 1'b0;
      endcase
    end else begin
      case (paddr)
        odt_pkg::OFF_CTRL: next_prdata = '0;
        odt_pkg::OFF_FLAGS: begin
          next_prdata[odt_pkg::FL_SENDING +: NP] = sending;
          next_prdata[odt_pkg::FL_ODERR +: NP] = odErr;
        end
        odt_pkg::OFF_STATUS: next_prdata[odt_pkg::ST_W-1:0] = status;
        odt_pkg::OFF_MASK: next_prdata[odt_pkg::ST_W-1:0] = mask;
        default: next_hit = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verification/odt_host_model.sv]
// host-side partner: paces received characters, finishes on-demand sends
`default_nettype none
module odt_host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] odGo,
  input wire logic [7:0] txLat,
  output logic [1:0] rxChar,
  output logic [1:0] rxMsgEnd,
  output logic [1:0] txDone
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxChar = 2'h0;
    rxMsgEnd = 2'h0;
    txDone = 2'h0;
  end
  // each started send takes txLat + 1 cycles on the wire
  for (genvar p = 0; p < 2; p++) begin : g_port
    int left;
    always @(posedge core_clk) begin
      txDone[p] <= 1'b0;
      if (rst)
        left <= 0;
      else if (odGo[p])
        left <= txLat + 1;
      else if (left == 1) begin
        txDone[p] <= 1'b1;
        left <= 0;
      end else if (left > 1)
        left <= left - 1;
    end
  end
  // n one-cycle characters gap + 2 cycles apart; an unfinished message is abandoned
  task automatic send_msg(int p, int n, int gap, bit fin);
    repeat (n) begin
      @(posedge core_clk);
      rxChar[p] <= 1'b1;
      @(posedge core_clk);
      rxChar[p] <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
    if (fin) begin
      rxMsgEnd[p] <= 1'b1;
      @(posedge core_clk);
      rxMsgEnd[p] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [verification/odt_top_sva.sv]
// port assertions for the on-demand send and rx timeout block
`default_nettype none
module odt_top_sva #(
  parameter bit FULL_RANGE = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] odGo,
  input wire logic [31:0] odStartOut,
  input wire logic [1:0] rxChar,
  input wire logic [1:0] rxError,
  input wire logic [31:0] linkTimeout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMAX = FULL_RANGE ? 3276 : 255;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  chk_one_wait:
  assert property (s_setup |=> s_answer) else $error("apb wait wrong");
  chk_map_error:
  assert property (pready && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > 8'h4c)) else $error("pslverr wrong");
  chk_write_zero:
  assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  chk_go_cause:
  assert property (odGo != 2'b00 |->
    $past(pready && pwrite && paddr == 8'h40)) else $error("stray send");
  chk_start_hold:
  assert property ($changed(odStartOut) |-> odGo != 2'b00)
    else $error("start index moved without send");
  chk_rx_pulse:
  assert property ((rxError & $past(rxError)) == 2'b00)
    else $error("rx error longer than one cycle");
  chk_rx_quiet:
  assert property (rxError[0] |-> !$past(rxChar[0]) && !$past(rxChar[0], 2))
    else $error("rx error right after a character");
  chk_tmo_range:
  assert property (linkTimeout[15:0] inside {[1:TMAX]} &&
    linkTimeout[31:16] inside {[1:TMAX]}) else $error("limit out of range");
endmodule
bind odt_top odt_top_sva #(.FULL_RANGE(FULL_RANGE)) odt_top_sva_inst (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .odGo, .odStartOut, .rxChar, .rxError, .linkTimeout);
`default_nettype wire

// [verification/odt_top_tb.sv]
// self-checking bench for the on-demand send and rx timeout block
`default_nettype none
module odt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, powerGood = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, txLat = 8'h04;
  logic [31:0] pwdata = 32'h0, paramTimeout = 32'h0;
  logic [31:0] paramFormat = 32'h0, paramStation = 32'h0;
  logic [1:0] paramValid = 2'h0;
  logic [31:0] prdata, odStartOut, odCountOut;
  logic [31:0] linkFormat, linkStation, linkTimeout;
  logic pready, pslverr, irq;
  logic [1:0] rxChar, rxMsgEnd, txDone, odGo, rxError;
  logic [31:0] seed = 32'h00007bde;
  logic [31:0] rdQ[$];
  logic [33:0] goQ[$];
  logic [1:0] rxQ[$];
  logic [15:0] badS[3] = '{16'd5, 16'd5, 16'd7998};
  logic [15:0] badN[3] = '{16'd0, 16'd65, 16'd3};
  int errCount = 0, nChecks = 0, cyc = 0, c;

  always #5 core_clk = ~core_clk;

  odt_top #(.TICK_CYCLES(4)) odt_top_inst (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .powerGood, .paramValid, .paramTimeout,
    .paramFormat, .paramStation, .rxChar, .rxMsgEnd, .txDone, .odGo,
    .odStartOut, .odCountOut, .rxError, .linkFormat, .linkStation,
    .linkTimeout);
  odt_host_model odt_host_model_inst (
    .core_clk, .rst, .odGo, .txLat, .rxChar, .rxMsgEnd, .txDone);

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string what, logic [33:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // this wait ends when pready is seen; the bench's cycle ceiling stops a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // settings written once, never while the port is sending
  task automatic send(int p, logic [15:0] s, logic [15:0] n);
    wr(8'(32 * p), {16'h0, s});
    wr(8'(32 * p + 4), {16'h0, n});
    rd(8'(32 * p), {16'h0, s});
    goQ.push_back({2'(1 << p), s, n});
    wr(8'h40, 32'(1 << p));
    rd(8'h44, 32'(1 << p));
    repeat (24) @(posedge core_clk);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'(16 << p));
    wr(8'h48, 32'(16 << p));
  endtask

  task automatic power();
    powerGood <= 1'b0;
    repeat (4) @(posedge core_clk);
    powerGood <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      conclude();
    end
    if (psel && penable && pready && !pwrite)
      check("prdata", prdata, rdQ.pop_front());
    if (odGo != 2'b00)
      check("send", {odGo, odStartOut[16*odGo[1]+:16],
        odCountOut[16*odGo[1]+:16]}, goQ.pop_front());
    if (rxError != 2'b00)
      check("rxError", rxError, rxQ.pop_front());
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("tmo", linkTimeout, 32'h000a000a);
    for (int a = 0; a < 80; a += 4) begin
      if (a != 68 && a != 72)
        rd(8'(a), 32'h0);
    end
    rd(8'h50, 32'h0);
    wr(8'h20, 32'd7);
    wr(8'h24, 32'd3);
    wr(8'h04, 32'd64);
    wr(8'h48, 32'h3f);
    txLat <= 8'(rnd() % 16 + 4);
    send(0, 16'd7936, 16'd64);
    send(1, 16'd7, 16'd3);
    rd(8'h00, 32'd7936);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {16'h0, badS[i]});
      wr(8'h04, {16'h0, badN[i]});
      rd(8'h44, 32'h4);
    end
    wr(8'h40, 32'h1);
    wr(8'h4c, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 1'b1);
    rd(8'h48, 32'h1);
    wr(8'h48, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 1'b0);
    wr(8'h08, 32'hffff);
    power();
    check("tmo", linkTimeout[15:0], 16'h0ccc);
    wr(8'h08, 32'h0);
    wr(8'h28, 32'h3);
    wr(8'h0c, 32'h1234);
    paramFormat <= rnd();
    paramStation <= rnd();
    paramTimeout <= {16'd2, 16'(rnd())};
    paramValid <= 2'b10;
    repeat (4) @(posedge core_clk);
    check("tmo", linkTimeout[15:0], 16'h0ccc);
    power();
    check("tmo", linkTimeout, 32'h0002000a);
    check("fmt", linkFormat, {paramFormat[31:16], 16'h1234});
    check("stn", linkStation, {paramStation[31:16], 16'h0});
    // character gaps stay below the configured limit
    odt_host_model_inst.send_msg(0, 3, 30, 1'b1);
    repeat (60) @(posedge core_clk);
    rxQ.push_back(2'b01);
    odt_host_model_inst.send_msg(0, 1, 0, 1'b0);
    c = 0;
    while (rxError[0] !== 1'b1 && c < 60) begin
      @(posedge core_clk);
      c++;
    end
    check("gap", 1'(c >= 38 && c <= 43), 1'b1);
    odt_host_model_inst.send_msg(1, 4, 1, 1'b1);
    rxQ.push_back(2'b10);
    odt_host_model_inst.send_msg(1, 1, 0, 1'b0);
    repeat (20) @(posedge core_clk);
    check("rxq", 34'(rxQ.size()), 34'h0);
    conclude();
  end
endmodule
`default_nettype wire
